// ### design/msc_classify.sv
// sorts each finished receive frame into counter events, one pulse per
// counter per frame; assumes frame attributes are valid with frame_end_i
`timescale 1ns/1ps
`include "msc_defines.svh"
module msc_classify (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // settings
   input  wire logic        pause_honor_enable_i,
   input  wire logic [15:0] max_rx_frame_length_i,
   // receive frame logic
   input  wire logic        rx_active_i,
   input  wire logic        rx_symbol_error_in_i,
   input  wire logic        frame_end_i,
   input  wire logic        addr_match_i,
   input  wire logic        dest_bcast_i,
   input  wire logic        dest_group_i,
   input  wire logic [15:0] len_type_i,
   input  wire logic [15:0] opcode_i,
   input  wire logic [15:0] frame_len_i,
   input  wire logic        odd_nibble_i,
   input  wire logic        fcs_fail_i,
   // one-cycle events, one bit per counter
   output logic      [`MSC_NUM_CNT-1:0] event_o
);
   logic                    code_seen_r;
   logic                    code_err;
   logic                    align_err;
   logic                    crc_err;
   logic                    len_ok;
   logic                    clean;
   logic                    is_pause;
   logic [`MSC_NUM_CNT-1:0] ev_nxt;
   logic [`MSC_NUM_CNT-1:0] ev_r;

   // a symbol error in the closing cycle still marks the frame
   assign code_err  = code_seen_r | (rx_active_i & rx_symbol_error_in_i);
   assign align_err = odd_nibble_i & fcs_fail_i;
   assign crc_err   = ~odd_nibble_i & fcs_fail_i;
   assign len_ok    = (frame_len_i >= `MSC_MIN_LEN) && (frame_len_i <= max_rx_frame_length_i);
   assign clean     = ~crc_err & ~align_err & ~code_err;
   assign is_pause  = (len_type_i == `MSC_PAUSE_TYPE) && (opcode_i == `MSC_PAUSE_OPCODE);

   // overrun has no input here at all, so it cannot sway any count
   assign ev_nxt[`MSC_IDX_GOOD]  = frame_end_i & addr_match_i & len_ok & clean;
   assign ev_nxt[`MSC_IDX_BCAST] = frame_end_i & dest_bcast_i & len_ok & clean;
   assign ev_nxt[`MSC_IDX_GROUP] = frame_end_i & dest_group_i & ~dest_bcast_i & len_ok & clean;
   assign ev_nxt[`MSC_IDX_PAUSE] = frame_end_i & is_pause & pause_honor_enable_i & len_ok & clean;
   assign ev_nxt[`MSC_IDX_CRC]   = frame_end_i & addr_match_i & len_ok & crc_err
                                   & ~align_err & ~code_err;
   assign event_o = ev_r;

   // the symbol error latch lives for one frame; an error in the end cycle
   // already marks the ending frame, so it is not carried into the next one
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         code_seen_r <= 1'b0;
         ev_r        <= '0;
      end else begin
         code_seen_r <= (rx_active_i & rx_symbol_error_in_i & ~frame_end_i) | (code_seen_r & ~frame_end_i);
         ev_r        <= ev_nxt;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_good_frame: assert property (frame_end_i && addr_match_i && len_ok && clean
      |=> event_o[`MSC_IDX_GOOD]) else $error("good frame not counted");
   a_bcast_clean: assert property (event_o[`MSC_IDX_BCAST]
      |-> $past(dest_bcast_i && len_ok && clean)) else $error("broadcast counted without cause");
   a_group_not_bcast: assert property (frame_end_i && dest_bcast_i
      |=> !event_o[`MSC_IDX_GROUP]) else $error("broadcast counted as group");
   a_pause_gated: assert property (event_o[`MSC_IDX_PAUSE]
      |-> $past(pause_honor_enable_i && is_pause)) else $error("pause counted while not honoured");
   a_crc_even: assert property (event_o[`MSC_IDX_CRC]
      |-> $past(!odd_nibble_i && fcs_fail_i && addr_match_i && !code_err)) else $error("bad crc event");
   a_code_blocks: assert property (rx_active_i && rx_symbol_error_in_i && !frame_end_i ##1 frame_end_i
      |=> !event_o[`MSC_IDX_GOOD]) else $error("code error frame counted good");
   c_pause_frame: cover property (event_o[`MSC_IDX_PAUSE]);
   c_good_and_bcast: cover property (event_o[`MSC_IDX_GOOD] && event_o[`MSC_IDX_BCAST]);
endmodule

// ### design/msc_counter.sv
// one 32-bit statistics counter with increment, direct load and
// write-to-decrement; assumes single clock, synchronous active-high reset
`timescale 1ns/1ps
module msc_counter #(
   parameter int W = 32
) (
   // clock and reset
   input  wire logic         clk_i,
   input  wire logic         rst_i,
   // control
   input  wire logic         clear_i,
   input  wire logic         inc_i,
   input  wire logic         wr_i,
   input  wire logic         dec_mode_i,
   input  wire logic [W-1:0] wr_data_i,
   // state
   output logic      [W-1:0] count_o,
   output logic              above_o
);
   logic [W-1:0] cnt_r;
   logic [W-1:0] cnt_nxt;
   logic [W-1:0] bumped;
   logic [W-1:0] dec_val;
   logic [W-1:0] load_val;
   logic [W-1:0] inc_w;

   // an event in the write cycle is added first, so neither is lost
   assign inc_w    = {{(W-1){1'b0}}, inc_i};
   assign bumped   = cnt_r + inc_w;
   assign dec_val  = (wr_data_i > bumped) ? '0 : bumped - wr_data_i;
   assign load_val = wr_data_i + inc_w;
   assign cnt_nxt  = clear_i ? '0 : (wr_i ? (dec_mode_i ? dec_val : load_val) : bumped);
   assign count_o  = cnt_r;
   assign above_o  = cnt_r[W-1];

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_dec_subtract: assert property (wr_i && dec_mode_i && !inc_i && !clear_i && wr_data_i <= cnt_r
      |=> cnt_r == $past(cnt_r) - $past(wr_data_i)) else $error("decrement write gave wrong count");
   a_dec_floor: assert property (wr_i && dec_mode_i && !clear_i && wr_data_i > cnt_r + inc_w
      |=> cnt_r == '0) else $error("oversized decrement did not floor at zero");
   a_direct_load: assert property (wr_i && !dec_mode_i && !clear_i
      |=> cnt_r == $past(wr_data_i) + $past(inc_w)) else $error("direct write not loaded");
   a_wrap_zero: assert property (inc_i && !wr_i && !clear_i && &cnt_r
      |=> cnt_r == '0) else $error("counter did not wrap to zero");
endmodule

// ### design/msc_stats_top.sv
// receive statistics counter bank with a classic wishbone register slave
// assumes a single 125 MHz clock, synchronous active-high reset, and
// frame attributes from the receive frame logic valid with frame_end_i
//
// The register offsets and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
// offsets, field positions and counts shared with the submodules
`include "msc_defines.svh"

module msc_stats_top #(
   parameter int CNT_W = 32
) (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // wishbone slave
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [7:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   // receive frame logic
   input  wire logic        rx_active_i,
   input  wire logic        rx_symbol_error_in_i,
   input  wire logic        frame_end_i,
   input  wire logic        addr_match_i,
   input  wire logic        dest_bcast_i,
   input  wire logic        dest_group_i,
   input  wire logic [15:0] len_type_i,
   input  wire logic [15:0] opcode_i,
   input  wire logic [15:0] frame_len_i,
   input  wire logic        odd_nibble_i,
   input  wire logic        fcs_fail_i,
   // statistics interrupt
   output logic             counter_irq_pending_o
);
   // bus handshake
   logic        ack_r;
   logic        req;
   logic        wr_commit;
   logic        full_word;
   logic [31:0] rd_r;
   logic [31:0] rd_mux;

   // register decode
   logic        hit_ctrl;
   logic        hit_maxlen;
   logic        hit_status;
   logic [`MSC_NUM_CNT-1:0] hit_cnt;

   // settings
   logic [2:0]  port_control_reg_r;
   logic [15:0] max_rx_frame_length_r;
   logic        link_interface_enable;
   logic        pause_honor_enable;
   logic        irq_enable;

   // start-up clear sequencer
   msc_pkg::msc_init_e init_st_r;
   logic [5:0]  init_cnt_r;
   logic        clear_now;

   // counter bank
   logic [`MSC_NUM_CNT-1:0] cnt_event;
   logic [`MSC_NUM_CNT-1:0] cnt_wr;
   logic [`MSC_NUM_CNT-1:0] cnt_above;
   msc_pkg::msc_word_t      cnt_val [`MSC_NUM_CNT];
   logic [31:0]             status_word;
   logic                    any_above;
   logic                    irq_r;

   // a request is taken while ack is low; the write lands on the ack edge,
   // which is the edge where the master samples ack
   assign req       = wb_cyc_i & wb_stb_i;
   assign wr_commit = req & wb_we_i & ack_r;
   assign full_word = (wb_sel_i == 4'hF);

   // address decode on byte offsets
   assign hit_cnt[`MSC_IDX_GOOD]  = (wb_adr_i == `MSC_OFS_GOOD);
   assign hit_cnt[`MSC_IDX_BCAST] = (wb_adr_i == `MSC_OFS_BCAST);
   assign hit_cnt[`MSC_IDX_GROUP] = (wb_adr_i == `MSC_OFS_GROUP);
   assign hit_cnt[`MSC_IDX_PAUSE] = (wb_adr_i == `MSC_OFS_PAUSE);
   assign hit_cnt[`MSC_IDX_CRC]   = (wb_adr_i == `MSC_OFS_CRC);
   assign hit_ctrl                = (wb_adr_i == `MSC_OFS_CTRL);
   assign hit_maxlen              = (wb_adr_i == `MSC_OFS_MAXLEN);
   assign hit_status              = (wb_adr_i == `MSC_OFS_STATUS);

   // control fields
   assign link_interface_enable = port_control_reg_r[`MSC_CTRL_LINK_EN];
   assign pause_honor_enable    = port_control_reg_r[`MSC_CTRL_PAUSE_EN];
   assign irq_enable            = port_control_reg_r[`MSC_CTRL_IRQ_EN];

   // partial-width writes to a counter are dropped, since a half-updated
   // count could not be subtracted sensibly
   assign cnt_wr = hit_cnt & {`MSC_NUM_CNT{wr_commit & full_word}};

   // status word: per-counter threshold flags, pending and ready
   assign any_above   = |cnt_above;
   assign status_word = {22'h000000, (init_st_r == msc_pkg::MSC_ST_RUN), irq_r,
                         3'h0, cnt_above};

   // read mux; unmapped offsets read as zero and reads change nothing
   assign rd_mux = hit_cnt[`MSC_IDX_GOOD]  ? cnt_val[`MSC_IDX_GOOD]  :
                   hit_cnt[`MSC_IDX_BCAST] ? cnt_val[`MSC_IDX_BCAST] :
                   hit_cnt[`MSC_IDX_GROUP] ? cnt_val[`MSC_IDX_GROUP] :
                   hit_cnt[`MSC_IDX_PAUSE] ? cnt_val[`MSC_IDX_PAUSE] :
                   hit_cnt[`MSC_IDX_CRC]   ? cnt_val[`MSC_IDX_CRC]   :
                   hit_ctrl                ? {29'h00000000, port_control_reg_r} :
                   hit_maxlen              ? {16'h0000, max_rx_frame_length_r} :
                   hit_status              ? status_word : 32'h00000000;

   assign wb_ack_o              = ack_r;
   assign wb_dat_o              = rd_r;
   assign counter_irq_pending_o = irq_r;

   // bus slave: ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ack_r <= 1'b0;
         rd_r  <= 32'h00000000;
      end else begin
         ack_r <= req & ~ack_r;
         if (req & ~ack_r & ~wb_we_i) begin
            rd_r <= rd_mux;
         end
      end
   end

   // settings registers; byte lanes are honoured here since these are not counters
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         port_control_reg_r    <= `MSC_CTRL_RST;
         max_rx_frame_length_r <= `MSC_MAXLEN_RST;
      end else begin
         if (wr_commit & hit_ctrl & wb_sel_i[0]) begin
            port_control_reg_r <= wb_dat_i[2:0];
         end
         if (wr_commit & hit_maxlen & wb_sel_i[0]) begin
            max_rx_frame_length_r[7:0] <= wb_dat_i[7:0];
         end
         if (wr_commit & hit_maxlen & wb_sel_i[1]) begin
            max_rx_frame_length_r[15:8] <= wb_dat_i[15:8];
         end
      end
   end

   // start-up clear: counts clocks after reset release, then clears once
   assign clear_now = (init_st_r == msc_pkg::MSC_ST_INIT) && (init_cnt_r == 6'(`MSC_INIT_CLKS - 1));

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         init_st_r  <= msc_pkg::MSC_ST_INIT;
         init_cnt_r <= 6'h00;
      end else begin
         case (init_st_r)
            msc_pkg::MSC_ST_INIT: begin
               init_cnt_r <= init_cnt_r + 6'h01;
               if (clear_now) begin
                  init_st_r <= msc_pkg::MSC_ST_RUN;
               end
            end
            msc_pkg::MSC_ST_RUN: begin
               init_cnt_r <= init_cnt_r;
            end
            default: begin
               init_st_r <= msc_pkg::MSC_ST_INIT;
            end
         endcase
      end
   end

   // frame sorting into one pulse per counter
   msc_classify u_classify (
      .clk_i                 (clk_i),
      .rst_i                 (rst_i),
      .pause_honor_enable_i  (pause_honor_enable),
      .max_rx_frame_length_i (max_rx_frame_length_r),
      .rx_active_i           (rx_active_i),
      .rx_symbol_error_in_i  (rx_symbol_error_in_i),
      .frame_end_i           (frame_end_i),
      .addr_match_i          (addr_match_i),
      .dest_bcast_i          (dest_bcast_i),
      .dest_group_i          (dest_group_i),
      .len_type_i            (len_type_i),
      .opcode_i              (opcode_i),
      .frame_len_i           (frame_len_i),
      .odd_nibble_i          (odd_nibble_i),
      .fcs_fail_i            (fcs_fail_i),
      .event_o               (cnt_event)
   );

   // counter bank; the mode bit is read live, so it applies to the very write
   for (genvar g = 0; g < `MSC_NUM_CNT; g++) begin : g_cnt
      msc_counter #(
         .W (CNT_W)
      ) u_cnt (
         .clk_i      (clk_i),
         .rst_i      (rst_i),
         .clear_i    (clear_now),
         .inc_i      (cnt_event[g]),
         .wr_i       (cnt_wr[g]),
         .dec_mode_i (link_interface_enable),
         .wr_data_i  (wb_dat_i),
         .count_o    (cnt_val[g]),
         .above_o    (cnt_above[g])
      );
   end

   // interrupt follows the threshold flags, so it falls by itself once the
   // host has decremented every large counter
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_r <= 1'b0;
      end else begin
         irq_r <= irq_enable & any_above;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_init_clear: assert property ($fell(rst_i) |-> ##37 clear_now ##1
      (cnt_val[`MSC_IDX_GOOD] == 32'h00000000 && cnt_val[`MSC_IDX_CRC] == 32'h00000000))
      else $error("counters not cleared 38 clocks after reset");
   a_init_once: assert property ((init_st_r == msc_pkg::MSC_ST_RUN) |-> !clear_now)
      else $error("start-up clear repeated");
   a_part_write: assert property (wr_commit && !full_word |-> cnt_wr == '0)
      else $error("partial write reached a counter");
   a_irq_raise: assert property (irq_enable && any_above |=> counter_irq_pending_o)
      else $error("pending not raised at threshold");
   a_irq_drop: assert property (!any_above |=> !counter_irq_pending_o)
      else $error("pending held with no counter at threshold");
   a_read_clean: assert property (wr_commit == 1'b0 && !cnt_event[`MSC_IDX_GOOD] && !clear_now
      |=> $stable(cnt_val[`MSC_IDX_GOOD])) else $error("counter moved without cause");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   // every frame event outside a counter write or the start-up clear must reach its counter as exactly one step
   a_good_bump: assert property (cnt_event[`MSC_IDX_GOOD] && !cnt_wr[`MSC_IDX_GOOD] && !clear_now
      |=> cnt_val[`MSC_IDX_GOOD] == $past(cnt_val[`MSC_IDX_GOOD]) + 32'h00000001)
      else $error("good count missed an event");
   a_bcast_bump: assert property (cnt_event[`MSC_IDX_BCAST] && !cnt_wr[`MSC_IDX_BCAST] && !clear_now
      |=> cnt_val[`MSC_IDX_BCAST] == $past(cnt_val[`MSC_IDX_BCAST]) + 32'h00000001)
      else $error("broadcast count missed an event");
   a_group_bump: assert property (cnt_event[`MSC_IDX_GROUP] && !cnt_wr[`MSC_IDX_GROUP] && !clear_now
      |=> cnt_val[`MSC_IDX_GROUP] == $past(cnt_val[`MSC_IDX_GROUP]) + 32'h00000001)
      else $error("group count missed an event");
   a_pause_bump: assert property (cnt_event[`MSC_IDX_PAUSE] && !cnt_wr[`MSC_IDX_PAUSE] && !clear_now
      |=> cnt_val[`MSC_IDX_PAUSE] == $past(cnt_val[`MSC_IDX_PAUSE]) + 32'h00000001)
      else $error("pause count missed an event");
   a_crc_bump: assert property (cnt_event[`MSC_IDX_CRC] && !cnt_wr[`MSC_IDX_CRC] && !clear_now
      |=> cnt_val[`MSC_IDX_CRC] == $past(cnt_val[`MSC_IDX_CRC]) + 32'h00000001)
      else $error("crc count missed an event");
   // the answer to every request comes exactly one cycle later
   a_ack_answer: assert property (req && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered in the next cycle");
   // read data is the register value at the taking edge
   a_read_value: assert property (req && !wb_ack_o && !wb_we_i |=> wb_dat_o == $past(rd_mux))
      else $error("read data not the value at the request");
   // pending stays low while the enable is clear
   a_irq_gated: assert property (!irq_enable |=> !counter_irq_pending_o)
      else $error("pending raised while disabled");
   a_init_bound: assert property (init_st_r == msc_pkg::MSC_ST_INIT
      |-> init_cnt_r <= 6'(`MSC_INIT_CLKS - 1)) else $error("start-up counter ran past its end");

   // the start-up clear reaches every counter, not only the two checked above
   a_clear_rest: assert property (clear_now |=> cnt_val[`MSC_IDX_BCAST] == 32'h00000000
      && cnt_val[`MSC_IDX_GROUP] == 32'h00000000 && cnt_val[`MSC_IDX_PAUSE] == 32'h00000000)
      else $error("start-up clear missed a counter");
   // the mode bit must be in place before the next counter write
   a_ctrl_load: assert property (wr_commit && hit_ctrl && wb_sel_i[0]
      |=> port_control_reg_r == $past(wb_dat_i[2:0])) else $error("port control not loaded");
   // the length window follows the host's full-width write
   a_maxlen_load: assert property (wr_commit && hit_maxlen && wb_sel_i[1:0] == 2'h3
      |=> max_rx_frame_length_r == $past(wb_dat_i[15:0])) else $error("max length not loaded");
   // a direct write and an event in one cycle must both be kept
   a_both_apply: assert property (cnt_wr[`MSC_IDX_GOOD] && cnt_event[`MSC_IDX_GOOD]
      && !link_interface_enable && !clear_now
      |=> cnt_val[`MSC_IDX_GOOD] == $past(wb_dat_i) + 32'h00000001)
      else $error("write and event together lost one");
   c_dec_write: cover property (wr_commit && full_word && link_interface_enable && hit_cnt[`MSC_IDX_GOOD]);
   c_irq_cycle: cover property (counter_irq_pending_o ##[1:200] !counter_irq_pending_o);
   c_write_and_event: cover property (cnt_wr[`MSC_IDX_GOOD] && cnt_event[`MSC_IDX_GOOD]);
endmodule

// ### inc/msc_defines.svh
// constants of the receive statistics counter block: offsets, field positions,
// reset values and timing counts; included by the classifier, the top and the bench by bare name
`ifndef MSC_DEFINES_SVH
`define MSC_DEFINES_SVH

// byte offsets on the register bus (word aligned)
`define MSC_OFS_GOOD      8'h00
`define MSC_OFS_BCAST     8'h04
`define MSC_OFS_GROUP     8'h08
`define MSC_OFS_PAUSE     8'h0C
`define MSC_OFS_CRC       8'h10
`define MSC_OFS_CTRL      8'h20
`define MSC_OFS_MAXLEN    8'h24
`define MSC_OFS_STATUS    8'h28

// counter slots, in the order of the offsets above
`define MSC_NUM_CNT       5
`define MSC_IDX_GOOD      0
`define MSC_IDX_BCAST     1
`define MSC_IDX_GROUP     2
`define MSC_IDX_PAUSE     3
`define MSC_IDX_CRC       4

// port control register fields
`define MSC_CTRL_LINK_EN  0
`define MSC_CTRL_PAUSE_EN 1
`define MSC_CTRL_IRQ_EN   2
`define MSC_CTRL_RST      3'h0

// status register fields
`define MSC_STAT_ABOVE_LO 0
`define MSC_STAT_PEND     8
`define MSC_STAT_READY    9

// frame length window and reset value of the maximum length
`define MSC_MIN_LEN       16'h0040
`define MSC_MAXLEN_RST    16'h05EE

// mac control frame identity
`define MSC_PAUSE_TYPE    16'h8808
`define MSC_PAUSE_OPCODE  16'h0001

// clocks from reset release to the forced clear of every counter
`define MSC_INIT_CLKS     38

`endif

// ### inc/msc_pkg.sv
// types shared by the receive statistics counter block
// assumes msc_defines.svh holds every number
package msc_pkg;
   typedef logic [31:0] msc_word_t;
   typedef enum logic {MSC_ST_INIT, MSC_ST_RUN} msc_init_e;
endpackage

// ### tb/mac_rx_statistics_counters_tb_top.sv
// self-checking bench of the receive statistics counter bank
// assumes msc_rx_model as frame source and a wishbone master in tasks
`timescale 1ns/1ps
`include "msc_defines.svh"
module mac_rx_statistics_counters_tb_top;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        counter_irq_pending_o;
   logic        go = 1'b0;
   logic [53:0] frm = '0;
   logic        act, sym, fend;
   logic [52:0] at;
   logic [31:0] exp_c [5] = '{default: 32'h0};
   logic [31:0] exp_q [$];
   string       nm_q [$];
   logic [15:0] lens [5] = '{16'h003F, 16'h0040, 16'h05EE, 16'h05EF, 16'h0200};
   logic [31:0] v;
   int          n_fail = 0;
   int          checked = 0;
   always #4 clk_i = ~clk_i;
   msc_rx_model u_rx (.clk_i, .rst_i, .go_i(go), .frm_i(frm), .rx_active_o(act), .sym_err_o(sym),
                      .frame_end_o(fend), .attr_o(at));
   msc_stats_top dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i,
      .wb_dat_o, .wb_ack_o, .rx_active_i(act), .rx_symbol_error_in_i(sym), .frame_end_i(fend),
      .addr_match_i(at[52]), .dest_bcast_i(at[51]), .dest_group_i(at[50]), .len_type_i(at[49:34]),
      .opcode_i(at[33:18]), .frame_len_i(at[17:2]), .odd_nibble_i(at[1]), .fcs_fail_i(at[0]),
      .counter_irq_pending_o);
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] ex);
      checked++;
      if (seen !== ex) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, ex, seen);
      end
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // classic single cycle; request held until ack is sampled, then released
   task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
      {wb_adr_i, wb_dat_i, wb_sel_i} <= {a, d, s};
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1) begin
         n_fail++;
         print_verdict();
      end
      {wb_cyc_i, wb_stb_i} <= 2'b00;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ex, input string nm);
      exp_q.push_back(ex);
      nm_q.push_back(nm);
      bus(1'b0, a, 32'h0, 4'hF);
   endtask
   task automatic rd_all();
      for (int i = 0; i < 5; i++) rd(8'(i * 4), exp_c[i], $sformatf("counter%0d", i));
   endtask
   // one frame; fx gives a clean matched 64-byte frame, otherwise random
   task automatic frame(input logic pen, input logic fx);
      logic am, bc, gr, se, fc, od, ok, cl;
      logic [15:0] lt, op, ln;
      am = fx | (($urandom % 4) != 0);
      bc = ($urandom % 3) == 0;
      gr = bc | $urandom % 2;
      se = !fx && ($urandom % 5) == 0;
      fc = !fx && ($urandom % 3) == 0;
      od = fc & $urandom % 2;
      lt = ($urandom % 2) ? `MSC_PAUSE_TYPE : 16'h0800;
      op = ($urandom % 2) ? `MSC_PAUSE_OPCODE : 16'h0002;
      ln = fx ? 16'h0040 : lens[$urandom % 5];
      ok = ln >= `MSC_MIN_LEN && ln <= `MSC_MAXLEN_RST;
      cl = ok && !fc && !se;
      exp_c[0] += 32'(am && cl);
      exp_c[1] += 32'(cl && bc);
      exp_c[2] += 32'(cl && gr && !bc);
      exp_c[3] += 32'(cl && pen && lt == `MSC_PAUSE_TYPE && op == `MSC_PAUSE_OPCODE);
      exp_c[4] += 32'(am && ok && fc && !od && !se);
      @(posedge clk_i);
      go <= 1'b1;
      frm <= {se, am, bc, gr, lt, op, ln, od, fc};
      @(posedge clk_i);
      go <= 1'b0;
      repeat (5) @(posedge clk_i);
   endtask
   // read results are compared at the ack edge against the oldest note
   always @(posedge clk_i) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) check(nm_q.pop_front(), wb_dat_o,
         exp_q.pop_front());
   end
   initial begin
      v = $urandom(87096);
      repeat (3) @(posedge clk_i);
      rst_i <= 1'b0;
      bus(1'b1, `MSC_OFS_GOOD, 32'h5, 4'hF);
      repeat (40) @(posedge clk_i);
      rd(`MSC_OFS_STATUS, 32'h200, "status");
      rd_all();
      $display("test startup done");
      v = $urandom;
      bus(1'b1, `MSC_OFS_GOOD, v, 4'hF);
      bus(1'b1, `MSC_OFS_GOOD, ~v, 4'h3);
      rd(`MSC_OFS_GOOD, v, "good");
      bus(1'b1, 8'h3C, v, 4'hF);
      rd(8'h3C, 32'h0, "unmapped");
      bus(1'b1, `MSC_OFS_GOOD, 32'h0, 4'hF);
      rd(`MSC_OFS_GOOD, 32'h0, "good");
      rd(`MSC_OFS_MAXLEN, {16'h0000, `MSC_MAXLEN_RST}, "max length");
      bus(1'b1, `MSC_OFS_MAXLEN, 32'h00000200, 4'hF);
      rd(`MSC_OFS_MAXLEN, 32'h00000200, "max length");
      bus(1'b1, `MSC_OFS_MAXLEN, {16'h0000, `MSC_MAXLEN_RST}, 4'hF);
      $display("test direct done");
      bus(1'b1, `MSC_OFS_CTRL, 32'h2, 4'hF);
      repeat (30) frame(1'b1, 1'b0);
      bus(1'b1, `MSC_OFS_CTRL, 32'h0, 4'hF);
      repeat (30) frame(1'b0, 1'b0);
      rd_all();
      bus(1'b1, `MSC_OFS_GOOD, 32'hFFFFFFFF, 4'hF);
      exp_c[0] = 32'hFFFFFFFF;
      frame(1'b0, 1'b1);
      rd(`MSC_OFS_GOOD, exp_c[0], "good wrap");
      $display("test frames done");
      bus(1'b1, `MSC_OFS_CTRL, 32'h4, 4'hF);
      bus(1'b1, `MSC_OFS_CRC, 32'h80000000, 4'hF);
      repeat (3) @(posedge clk_i);
      check("irq high", {31'h0, counter_irq_pending_o}, 32'h1);
      rd(`MSC_OFS_STATUS, 32'h310, "status");
      bus(1'b1, `MSC_OFS_CTRL, 32'h5, 4'hF);
      bus(1'b1, `MSC_OFS_CRC, 32'h1, 4'hF);
      repeat (3) @(posedge clk_i);
      check("irq low", {31'h0, counter_irq_pending_o}, 32'h0);
      rd(`MSC_OFS_CRC, 32'h7FFFFFFF, "crc");
      bus(1'b1, `MSC_OFS_CRC, 32'h80000000, 4'hF);
      rd(`MSC_OFS_CRC, 32'h0, "crc");
      bus(1'b1, `MSC_OFS_BCAST, 32'hFFFFFFFF, 4'hF);
      rd(`MSC_OFS_BCAST, 32'h0, "bcast");
      $display("test decrement done");
      repeat (2) @(posedge clk_i);
      print_verdict();
   end
endmodule

// ### tb/msc_rx_model.sv
// behavioural receive frame logic feeding the statistics block
// assumes one clock, synchronous active-high reset; one frame per go pulse
`timescale 1ns/1ps
module msc_rx_model (
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   // frame request: {symbol error, attributes}
   input  wire logic        go_i,
   input  wire logic [53:0] frm_i,
   // towards the statistics block
   output logic             rx_active_o,
   output logic             sym_err_o,
   output logic             frame_end_o,
   output logic      [52:0] attr_o
);
   logic [53:0] f_r;
   logic [1:0]  ph_r;
   logic        busy_r;
   // three-cycle frame: start, symbol error slot, end; go while busy is dropped
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         busy_r <= 1'b0;
         ph_r   <= 2'h0;
         f_r    <= '0;
      end else if (go_i && !busy_r) begin
         busy_r <= 1'b1;
         ph_r   <= 2'h0;
         f_r    <= frm_i;
      end else if (busy_r) begin
         ph_r   <= ph_r + 2'h1;
         busy_r <= (ph_r != 2'h2);
      end
   end
   // symbol error only inside reception, so a stray one cannot be counted
   assign rx_active_o = busy_r;
   assign sym_err_o   = busy_r && ph_r == 2'h1 && f_r[53];
   assign frame_end_o = busy_r && ph_r == 2'h2;
   // attributes inverted outside the end cycle so stale values never pass
   assign attr_o = frame_end_o ? f_r[52:0] : ~f_r[52:0];
endmodule
